// ===== rtl/solc_pkg.sv
/*
 Constants, types and field layout of the scaled output level control block.
 Assumes one 200 MHz clock domain and a 32-bit AXI4-Lite register bus.
*/
`default_nettype none
package solc_pkg;
    localparam logic [7:0]  CTRL_OFS   = 8'h00;
    localparam logic [7:0]  GAIN_OFS   = 8'h04;
    localparam logic [7:0]  OFFS_OFS   = 8'h08;
    localparam logic [7:0]  PANEL_OFS  = 8'h0C;
    localparam logic [7:0]  LEVEL_OFS  = 8'h10;
    localparam logic [7:0]  REL_OFS    = 8'h14;
    localparam logic [7:0]  STAT_OFS   = 8'h18;
    localparam int          CTRL_EN    = 0;
    localparam int          CTRL_REL   = 1;
    localparam int          CTRL_TEMP  = 2;
    localparam int          CTRL_RATIO = 3;
    localparam int          PNL_TOG    = 0;
    localparam int          PNL_MENU   = 1;
    localparam int          PNL_ENTER  = 2;
    localparam int          STAT_ACT   = 0;
    localparam int          STAT_BUSY  = 1;
    localparam int          STAT_REL   = 2;
    localparam logic [31:0] GAIN_RST   = 32'h0001_0000;
    localparam logic [31:0] OFFS_RST   = 32'h0000_0000;
    localparam int          GAIN_FRAC  = 16;
    localparam int          ONE_SHIFT  = 20;
    localparam int          MV_PER_V   = 1000;
    localparam int          LIMIT_MV   = 1200;
    localparam int          TEMP_FS_MV = 1200;
    localparam int          RATIO_MV   = 1000;
    localparam longint      LIMIT_CODE = (longint'(LIMIT_MV) << ONE_SHIFT) / longint'(MV_PER_V);
    localparam logic [24:0] TEMP_SCALE = 25'((TEMP_FS_MV << ONE_SHIFT) / MV_PER_V);
    localparam logic [23:0] RATIO_DIV  = 24'((RATIO_MV << ONE_SHIFT) / MV_PER_V);
    localparam logic [43:0] QMAX       = 44'h00001000000;
    localparam int          DIV_STEPS  = 44;
    localparam logic [5:0]  DIV_LAST   = 6'(DIV_STEPS - 1);
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {CALC_IDLE, CALC_DIV, CALC_FIN} solc_calc_type;
    typedef enum logic [1:0] {MENU_IDLE, MENU_GAIN, MENU_OFFS} solc_menu_type;
endpackage
`default_nettype wire

// ===== rtl/solc_top.sv
/*
 Scaled output level control: AXI4-Lite registers, trigger-time parameter
 latching, a serial divider for reading over range, gain, offset, rel and limit.
 Assumes readings, triggers and the bus all run on aclk.
*/
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module solc_top (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [7:0]         awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [7:0]         araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    input  wire logic               rdg_trig,
    input  wire logic               rdg_done,
    input  wire logic signed [23:0] rdg_value,
    input  wire logic signed [23:0] rdg_range,
    output logic signed [23:0]      scaled_voltage_output
);
    typedef struct packed {
        logic                   awready;
        logic                   wready;
        logic                   arready;
        logic                   aw_got;
        logic                   w_got;
        logic [7:0]             awaddr;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [1:0]             rresp;
        logic [31:0]            rdata;
        logic                   out_en;
        logic                   en_act;
        logic                   rel_en;
        logic                   temp;
        logic                   ratio;
        logic [31:0]            gain;
        logic [31:0]            off;
        logic [31:0]            gain_use;
        logic [31:0]            off_use;
        logic signed [23:0]     rel_val;
        logic signed [23:0]     raw;
        logic signed [23:0]     out;
        solc_pkg::solc_menu_type menu;
        solc_pkg::solc_calc_type calc;
        logic                   neg;
        logic                   temp_use;
        logic [5:0]             cnt;
        logic [43:0]            num;
        logic [23:0]            rem;
        logic [23:0]            div;
    } solc_state_type;

    solc_state_type     s;
    solc_state_type     n;
    logic               wr_go;
    logic               ctrl_wr;
    logic               pnl_wr;
    logic               rel_go;
    logic [31:0]        cw;
    logic [31:0]        pw;
    logic [23:0]        rdg_mag;
    logic [23:0]        rng_mag;
    logic [24:0]        dt;
    logic [24:0]        q_sat;
    logic [24:0]        q_t;
    logic signed [63:0] sq;
    logic signed [63:0] prod;
    logic signed [63:0] lvl;
    logic signed [63:0] lvl_rel;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic signed [23:0] sat(input logic signed [63:0] v);
        // Clamp to the output swing
        if (v > solc_pkg::LIMIT_CODE) begin
            return 24'(solc_pkg::LIMIT_CODE);
        end else if (v < -solc_pkg::LIMIT_CODE) begin
            return 24'(-solc_pkg::LIMIT_CODE);
        end
        return 24'(v);
    endfunction

    always_comb begin
        n = s;
        rel_go = 1'b0;
        wr_go = s.aw_got && s.w_got && !s.bvalid;
        ctrl_wr = wr_go && (s.awaddr == solc_pkg::CTRL_OFS);
        pnl_wr = wr_go && (s.awaddr == solc_pkg::PANEL_OFS);
        cw = merge({28'h0, s.ratio, s.temp, s.rel_en, s.out_en}, s.wdata, s.wstrb);
        pw = merge(32'h0, s.wdata, s.wstrb);
        rdg_mag = rdg_value[23] ? 24'(-rdg_value) : rdg_value;
        rng_mag = rdg_range[23] ? 24'(-rdg_range) : rdg_range;
        dt = {s.rem, s.num[43]};
        q_sat = (s.num > solc_pkg::QMAX) ? solc_pkg::QMAX[24:0] : s.num[24:0];
        q_t = s.temp_use ? 25'((50'(q_sat) * 50'(solc_pkg::TEMP_SCALE)) >> solc_pkg::ONE_SHIFT) : q_sat;
        sq = $signed({39'h0, q_t});
        if (s.neg) begin
            sq = -sq;
        end
        prod = sq * $signed({{32{s.gain_use[31]}}, s.gain_use});
        lvl = (prod >>> solc_pkg::GAIN_FRAC) - $signed({{32{s.off_use[31]}}, s.off_use});
        lvl_rel = lvl - $signed({{40{s.rel_val[23]}}, s.rel_val});

        if (rdg_trig) begin
            n.gain_use = s.gain;
            n.off_use = s.off;
            n.en_act = s.out_en;
        end

        unique case (s.calc)
            solc_pkg::CALC_IDLE: begin
                if (rdg_done) begin
                    n.neg = rdg_value[23];
                    n.num = {rdg_mag, 20'h0};
                    // ratio of one is one volt
                    n.div = s.ratio ? solc_pkg::RATIO_DIV : rng_mag;
                    n.temp_use = s.temp && !s.ratio;
                    n.rem = 24'h0;
                    n.cnt = 6'h0;
                    n.calc = solc_pkg::CALC_DIV;
                end
            end
            solc_pkg::CALC_DIV: begin
                if (dt >= {1'b0, s.div}) begin
                    n.rem = 24'(dt - {1'b0, s.div});
                    n.num = {s.num[42:0], 1'b1};
                end else begin
                    n.rem = dt[23:0];
                    n.num = {s.num[42:0], 1'b0};
                end
                n.cnt = s.cnt + 6'h1;
                if (s.cnt == solc_pkg::DIV_LAST) begin
                    n.calc = solc_pkg::CALC_FIN;
                end
            end
            solc_pkg::CALC_FIN: begin
                n.raw = sat(lvl);
                if (s.en_act) begin
                    n.out = s.rel_en ? sat(lvl_rel) : sat(lvl);
                end
                n.calc = solc_pkg::CALC_IDLE;
            end
        endcase

        if (awvalid && s.awready) begin
            n.aw_got = 1'b1;
            n.awaddr = awaddr;
        end
        if (wvalid && s.wready) begin
            n.w_got = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        if (s.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (wr_go) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = solc_pkg::RESP_OKAY;
            case (s.awaddr)
                solc_pkg::CTRL_OFS: begin
                    n.temp = cw[solc_pkg::CTRL_TEMP];
                    n.ratio = cw[solc_pkg::CTRL_RATIO];
                    if (!cw[solc_pkg::CTRL_EN]) begin
                        n.out_en = 1'b0;
                        n.en_act = 1'b0;
                        n.out = 24'sh0;
                    end else begin
                        n.out_en = 1'b1;
                    end
                    if (cw[solc_pkg::CTRL_REL]) begin
                        rel_go = 1'b1;
                    end else begin
                        n.rel_en = 1'b0;
                    end
                end
                solc_pkg::GAIN_OFS: begin
                    n.gain = merge(s.gain, s.wdata, s.wstrb);
                end
                solc_pkg::OFFS_OFS: begin
                    n.off = merge(s.off, s.wdata, s.wstrb);
                end
                solc_pkg::PANEL_OFS: begin
                    if (pw[solc_pkg::PNL_TOG]) begin
                        if (s.rel_en) begin
                            n.rel_en = 1'b0;
                        end else begin
                            rel_go = 1'b1;
                        end
                    end
                    if (pw[solc_pkg::PNL_MENU]) begin
                        if (s.menu != solc_pkg::MENU_IDLE) begin
                            n.menu = solc_pkg::MENU_IDLE;
                        end else if (s.out_en) begin
                            n.out_en = 1'b0;
                            n.en_act = 1'b0;
                            n.out = 24'sh0;
                        end else begin
                            n.menu = solc_pkg::MENU_GAIN;
                        end
                    end else if (pw[solc_pkg::PNL_ENTER]) begin
                        if (s.menu == solc_pkg::MENU_GAIN) begin
                            n.menu = solc_pkg::MENU_OFFS;
                        end else if (s.menu == solc_pkg::MENU_OFFS) begin
                            n.menu = solc_pkg::MENU_IDLE;
                            n.out_en = 1'b1;
                        end
                    end
                end
                solc_pkg::LEVEL_OFS, solc_pkg::REL_OFS, solc_pkg::STAT_OFS: begin
                end
                default: begin
                    n.bresp = solc_pkg::RESP_SLVERR;
                end
            endcase
        end

        if (rel_go) begin
            n.rel_en = 1'b1;
            n.rel_val = s.en_act ? s.raw : 24'sh0;
            if (s.en_act) begin
                n.out = 24'sh0;
            end
        end

        if (s.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rresp = solc_pkg::RESP_OKAY;
            n.rdata = 32'h0;
            case (araddr)
                solc_pkg::CTRL_OFS: n.rdata = {28'h0, s.ratio, s.temp, s.rel_en, s.out_en};
                solc_pkg::GAIN_OFS: n.rdata = s.gain;
                solc_pkg::OFFS_OFS: n.rdata = s.off;
                solc_pkg::PANEL_OFS: n.rdata = {30'h0, s.menu};
                solc_pkg::LEVEL_OFS: n.rdata = {{8{s.out[23]}}, s.out};
                solc_pkg::REL_OFS: n.rdata = {{8{s.rel_val[23]}}, s.rel_val};
                solc_pkg::STAT_OFS: begin
                    n.rdata[solc_pkg::STAT_ACT] = s.en_act;
                    n.rdata[solc_pkg::STAT_BUSY] = (s.calc != solc_pkg::CALC_IDLE);
                    n.rdata[solc_pkg::STAT_REL] = s.rel_en;
                end
                default: n.rresp = solc_pkg::RESP_SLVERR;
            endcase
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;
        n.arready = !n.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.gain <= solc_pkg::GAIN_RST;
            s.gain_use <= solc_pkg::GAIN_RST;
            s.off <= solc_pkg::OFFS_RST;
            s.off_use <= solc_pkg::OFFS_RST;
        end else begin
            s <= n;
        end
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rresp = s.rresp;
    assign rdata = s.rdata;
    assign scaled_voltage_output = s.out;

    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence calc_start;
        s.calc == solc_pkg::CALC_IDLE && rdg_done;
    endsequence
    sequence volt_start;
        s.calc == solc_pkg::CALC_IDLE && rdg_done && !s.ratio;
    endsequence
    sequence calc_run;
        s.calc == solc_pkg::CALC_DIV ##43 s.calc == solc_pkg::CALC_DIV ##1 s.calc == solc_pkg::CALC_FIN;
    endsequence

    out_limit_a: assert property (
        s.out <= solc_pkg::LIMIT_CODE && s.out >= -solc_pkg::LIMIT_CODE)
        else $error("output beyond limit");
    off_now_a: assert property (
        ctrl_wr && !cw[solc_pkg::CTRL_EN] |=> s.out == 24'sh0 && !s.en_act)
        else $error("disable did not zero output");
    on_trig_a: assert property (
        $rose(s.en_act) |-> $past(rdg_trig))
        else $error("enable applied without trigger");
    par_hold_a: assert property (
        $changed(s.gain_use) || $changed(s.off_use) |-> $past(rdg_trig))
        else $error("parameters changed without trigger");
    rel_take_a: assert property (
        rel_go && s.en_act |=> s.rel_en && s.rel_val == $past(s.raw) && s.out == 24'sh0)
        else $error("rel reference not latched");
    rel_again_a: assert property (
        ctrl_wr && cw[solc_pkg::CTRL_REL] && s.rel_en && s.en_act |=> s.rel_val == $past(s.raw))
        else $error("rel on again did not relatch");
    rel_tog_a: assert property (
        pnl_wr && pw[solc_pkg::PNL_TOG] |=> s.rel_en != $past(s.rel_en))
        else $error("panel toggle did not alternate rel");
    menu_on_a: assert property (
        pnl_wr && !pw[solc_pkg::PNL_MENU] && pw[solc_pkg::PNL_ENTER] && s.menu == solc_pkg::MENU_OFFS
        |=> s.out_en && s.menu == solc_pkg::MENU_IDLE)
        else $error("offset confirm did not enable");
    calc_len_a: assert property (
        calc_start |=> calc_run)
        else $error("reading computation length wrong");
    rng_mag_a: assert property (
        volt_start |=> s.div == ($past(rdg_range[23]) ? 24'(-$past(rdg_range)) : $past(rdg_range)))
        else $error("range not taken as magnitude");
    fin_out_a: assert property (
        s.calc == solc_pkg::CALC_FIN && s.en_act && !s.rel_en && !wr_go |=> s.out == s.raw)
        else $error("output not updated from level");
    rst_gain_a: assert property (
        $rose(aresetn) |-> s.gain == solc_pkg::GAIN_RST && s.off == solc_pkg::OFFS_RST)
        else $error("gain or offset default wrong");
    rst_off_a: assert property (
        $rose(aresetn) |-> !s.out_en && !s.rel_en)
        else $error("enables not off after reset");
endmodule
`default_nettype wire

// ===== verif/solc_recorder_model.sv
/*
 Model of the analogue recorder that watches the scaled output level.
 Assumes the level code of solc_pkg, 2^20 per volt, sampled on aclk.
*/
`timescale 1ns/100ps
`default_nettype none
module solc_recorder_model (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic signed [23:0] level,
    output logic                    over_limit
);
    logic over_reg;
    logic over_next;

    always_comb begin
        over_next = over_reg;
        if (longint'(level) > solc_pkg::LIMIT_CODE || longint'(level) < -solc_pkg::LIMIT_CODE) begin
            over_next = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            over_reg <= 1'b0;
        end else begin
            over_reg <= over_next;
        end
    end

    assign over_limit = over_reg;
endmodule
`default_nettype wire

// ===== verif/solc_tb_top.sv
/*
 Self-checking bench of the scaled output level control block.
 Assumes solc_pkg and solc_top; drives AXI4-Lite and reading pulses.
*/
`timescale 1ns/100ps
`default_nettype none
module scaled_output_level_control_tb_top;
    logic               aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic               awready, wready, bvalid, arready, rvalid;
    logic               rdg_trig, rdg_done, over_limit;
    logic [7:0]         awaddr, araddr;
    logic [31:0]        wdata, rdata;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp, last_bresp;
    logic signed [23:0] rdg_value, rdg_range, level, rv;
    logic [33:0]        exp_q[$];
    int                 fail_count = 0, checked = 0, cyc = 0, k, s, ev;

    solc_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .rdg_trig(rdg_trig), .rdg_done(rdg_done), .rdg_value(rdg_value), .rdg_range(rdg_range),
        .scaled_voltage_output(level));
    solc_recorder_model rec (.aclk(aclk), .aresetn(aresetn), .level(level), .over_limit(over_limit));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                done = 1'b1;
                last_bresp = bresp;
                bready <= 1'b0;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
        logic done;
        done = 1'b0;
        exp_q.push_back({r, e});
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                done = 1'b1;
                rready <= 1'b0;
            end
        end
    endtask

    task automatic rdg_go(input logic signed [23:0] v, input logic signed [23:0] r, input bit trig);
        @(posedge aclk);
        if (trig) begin
            rdg_trig <= 1'b1;
            @(posedge aclk);
            rdg_trig <= 1'b0;
        end
        rdg_done <= 1'b1; rdg_value <= v; rdg_range <= r;
        @(posedge aclk);
        rdg_done <= 1'b0; rdg_value <= ~v; rdg_range <= ~r;
        repeat (50) @(posedge aclk);
    endtask

    task automatic settle_zero;
        @(posedge aclk);
        #1;
    endtask

    always @(posedge aclk) begin
        if (rvalid && rready && exp_q.size() > 0) begin
            chk("rdata", rdata, exp_q[0][31:0]);
            chk("rresp", 32'(rresp), 32'(exp_q[0][33:32]));
            void'(exp_q.pop_front());
        end
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            test_done;
        end
    end

    initial begin
        aresetn = 1'b0; awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'hF; wvalid = 1'b0;
        bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0; rdg_trig = 1'b0;
        rdg_done = 1'b0; rdg_value = 24'h0; rdg_range = 24'h1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        k = $urandom(53);
        rd(solc_pkg::CTRL_OFS, 32'h0);
        rd(solc_pkg::GAIN_OFS, solc_pkg::GAIN_RST);
        rd(solc_pkg::OFFS_OFS, solc_pkg::OFFS_RST);
        rd(8'h1C, 32'h0, solc_pkg::RESP_SLVERR);
        wr(8'h1C, 32'h5);
        chk("bresp", 32'(last_bresp), 32'(solc_pkg::RESP_SLVERR));
        $display("test reset done");
        wr(solc_pkg::CTRL_OFS, 32'h1);
        rdg_go(24'sd1, 24'sd8, 1'b0);
        rd(solc_pkg::LEVEL_OFS, 32'h0);
        rdg_go(24'sd1, 24'sd8, 1'b1);
        rd(solc_pkg::LEVEL_OFS, 32'h0002_0000);
        wr(solc_pkg::GAIN_OFS, 32'h000A_0000);
        rdg_go(-24'sd512, -24'sd1024, 1'b1);
        rd(solc_pkg::LEVEL_OFS, 32'hFFEC_CCCD);
        $display("test scaling done");
        @(posedge aclk) rdg_trig <= 1'b1;
        @(posedge aclk) rdg_trig <= 1'b0;
        wr(solc_pkg::GAIN_OFS, 32'h0001_0000);
        wr(solc_pkg::OFFS_OFS, 32'h0004_0000);
        rdg_go(24'sd1, 24'sd8, 1'b0);
        rd(solc_pkg::LEVEL_OFS, 32'h0013_3333);
        rdg_go(24'sd1, 24'sd8, 1'b1);
        rd(solc_pkg::LEVEL_OFS, 32'hFFFE_0000);
        wr(solc_pkg::OFFS_OFS, 32'h0010_0000);
        wr(solc_pkg::CTRL_OFS, 32'h5);
        rdg_go(24'sd760, 24'sd760, 1'b1);
        rd(solc_pkg::LEVEL_OFS, 32'h0003_3333);
        wr(solc_pkg::OFFS_OFS, 32'h0);
        wr(solc_pkg::CTRL_OFS, 32'h9);
        rdg_go(24'sh066666, 24'sd5, 1'b1);
        rd(solc_pkg::LEVEL_OFS, 32'h0006_6666);
        wr(solc_pkg::CTRL_OFS, 32'h1);
        repeat (4) begin
            k = $urandom % 8;
            s = $urandom % 2;
            rv = 24'(k * 128);
            ev = k * 131072;
            rdg_go(s ? -rv : rv, 24'sd1024, 1'b1);
            rd(solc_pkg::LEVEL_OFS, 32'(s ? -ev : ev));
        end
        $display("test modes done");
        rdg_go(24'sd1, 24'sd8, 1'b1);
        wr(solc_pkg::CTRL_OFS, 32'h3);
        rd(solc_pkg::REL_OFS, 32'h0002_0000);
        rd(solc_pkg::LEVEL_OFS, 32'h0);
        rdg_go(24'sd3, 24'sd8, 1'b1);
        rd(solc_pkg::LEVEL_OFS, 32'h0004_0000);
        wr(solc_pkg::CTRL_OFS, 32'h3);
        rd(solc_pkg::REL_OFS, 32'h0006_0000);
        wr(solc_pkg::PANEL_OFS, 32'h1);
        rd(solc_pkg::STAT_OFS, 32'h1);
        rdg_go(24'sd2, 24'sd8, 1'b1);
        rd(solc_pkg::LEVEL_OFS, 32'h0004_0000);
        wr(solc_pkg::PANEL_OFS, 32'h1);
        rd(solc_pkg::REL_OFS, 32'h0004_0000);
        rd(solc_pkg::STAT_OFS, 32'h5);
        $display("test rel done");
        wr(solc_pkg::CTRL_OFS, 32'h0);
        settle_zero();
        chk("level", 32'(level), 32'h0);
        wr(solc_pkg::PANEL_OFS, 32'h2);
        rd(solc_pkg::PANEL_OFS, 32'h1);
        wr(solc_pkg::PANEL_OFS, 32'h4);
        rd(solc_pkg::PANEL_OFS, 32'h2);
        wr(solc_pkg::PANEL_OFS, 32'h4);
        rd(solc_pkg::PANEL_OFS, 32'h0);
        rdg_go(24'sd1, 24'sd8, 1'b1);
        rd(solc_pkg::LEVEL_OFS, 32'h0002_0000);
        wr(solc_pkg::PANEL_OFS, 32'h2);
        settle_zero();
        chk("level", 32'(level), 32'h0);
        chk("limit", 32'(over_limit), 32'h0);
        $display("test panel done");
        test_done;
    end
endmodule
`default_nettype wire
